// ---- src/dsp_master.sv ----
// Master end: generates SCL by a divider, runs one write or read transfer per command.
// Assumes one slave on the bus and no clock stretching.
module dsp_master (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Two-wire link
    dsp_if.master bus,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic [6:0] cmd_addr,
    input wire logic [7:0] cmd_index,
    input wire logic [7:0] cmd_data,
    input wire logic [7:0] cmd_count,
    output logic cmd_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic nack_seen
);
    import dsp_pkg::*;
    typedef enum logic [6:0] {
        M_IDLE = 7'b0000001,
        M_START = 7'b0000010,
        M_BYTE = 7'b0000100,
        M_RSTART = 7'b0001000,
        M_STOP = 7'b0010000,
        M_BUF = 7'b0100000,
        M_SETUP = 7'b1000000
    } dsp_mstate_t;
    typedef enum logic [2:0] {
        P_ADDR_W = 3'b001,
        P_INDEX = 3'b010,
        P_DATA = 3'b100
    } dsp_phase_t;
    typedef struct packed {
        dsp_mstate_t state;
        logic [2:0] phase;
        logic reading;
        logic [7:0] cnt;
        logic [3:0] bitn;
        logic half;
        logic [7:0] shift;
        logic [7:0] left;
        logic [6:0] addr;
        logic [7:0] index;
        logic [7:0] data;
        logic scl_oe_n;
        logic sda_oe_n;
        logic ready;
        logic [7:0] rdata;
        logic rvalid;
        logic nack;
    } dsp_master_t;
    dsp_master_t st, next_st;
    logic sda_lvl;
    dsp_sync u_sda (.mclk(mclk), .nrst(nrst), .pin(bus.sda), .level(sda_lvl), .rise(), .fall());
    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        if (st.cnt != BYTE_ZERO) begin
            next_st.cnt = st.cnt - CNT_ONE;
        end
        case (st.state)
            M_IDLE: begin
                if (cmd_valid && st.ready) begin
                    next_st.ready = 1'b0;
                    next_st.nack = 1'b0;
                    next_st.reading = cmd_read;
                    next_st.addr = cmd_addr;
                    next_st.index = cmd_index;
                    next_st.data = cmd_data;
                    next_st.left = cmd_count;
                    next_st.shift = {cmd_addr, 1'b0};
                    next_st.phase = P_ADDR_W;
                    next_st.state = M_START;
                    next_st.sda_oe_n = 1'b0;
                    next_st.cnt = SU_CNT;
                end
            end
            M_START, M_SETUP: begin
                if (st.cnt == BYTE_ZERO) begin
                    next_st.scl_oe_n = 1'b0;
                    next_st.state = M_BYTE;
                    next_st.bitn = BIT_ZERO;
                    next_st.half = 1'b0;
                    next_st.cnt = HALF_CNT;
                    next_st.sda_oe_n = next_st.shift[7];
                end
            end
            M_BYTE: begin
                if (st.cnt == BYTE_ZERO) begin
                    next_st.cnt = HALF_CNT;
                    next_st.half = ~st.half;
                    next_st.scl_oe_n = ~st.half;
                    if (!st.half) begin
                        if (st.bitn == BIT_ACK) begin
                            // Ninth clock high: sample acknowledge from the slave, or in read data pass on the received byte.
                            if (st.reading && st.phase == P_DATA) begin
                                next_st.rdata = st.shift;
                                next_st.rvalid = 1'b1;
                            end else if (sda_lvl) begin
                                next_st.nack = 1'b1;
                            end
                        end else begin
                            next_st.shift = {st.shift[6:0], sda_lvl};
                        end
                    end else if (st.bitn != BIT_ACK) begin
                        next_st.bitn = st.bitn + BIT_ONE;
                        if (st.bitn == BIT_ACK - BIT_ONE) begin
                            // Receiver answers: in reads the master acks all but the last byte.
                            next_st.sda_oe_n = (st.reading && st.phase == P_DATA) ? (st.left == IDX_ONE) : 1'b1;
                        end else begin
                            // The echoed bit filled the bottom at the rise, so the next bit is now on top.
                            next_st.sda_oe_n = (st.reading && st.phase == P_DATA) ? 1'b1 : st.shift[7];
                        end
                    end else begin
                        next_st.bitn = BIT_ZERO;
                        next_st.sda_oe_n = 1'b0;
                        if (st.nack || (st.phase == P_DATA && st.left == IDX_ONE)) begin
                            next_st.state = M_STOP;
                        end else if (st.phase == P_ADDR_W) begin
                            next_st.phase = st.reading && st.left == IDX_ONE && st.shift[0] ? P_DATA : P_INDEX;
                            next_st.shift = st.index;
                            next_st.sda_oe_n = st.index[7];
                            if (st.reading && st.shift[0]) begin
                                next_st.phase = P_DATA;
                                next_st.sda_oe_n = 1'b1;
                            end
                        end else if (st.phase == P_INDEX) begin
                            if (st.reading) begin
                                next_st.state = M_RSTART;
                                next_st.sda_oe_n = 1'b1;
                            end else begin
                                next_st.phase = P_DATA;
                                next_st.shift = st.data;
                                next_st.sda_oe_n = st.data[7];
                            end
                        end else begin
                            next_st.left = st.left - IDX_ONE;
                            next_st.sda_oe_n = st.reading ? 1'b1 : st.data[7];
                            next_st.shift = st.data;
                        end
                    end
                end
            end
            M_RSTART: begin
                if (st.cnt == BYTE_ZERO) begin
                    if (!st.scl_oe_n) begin
                        next_st.scl_oe_n = 1'b1;
                        next_st.cnt = SU_CNT;
                    end else begin
                        next_st.sda_oe_n = 1'b0;
                        next_st.shift = {st.addr, 1'b1};
                        next_st.phase = P_ADDR_W;
                        next_st.state = M_SETUP;
                        next_st.cnt = SU_CNT;
                    end
                end
            end
            M_STOP: begin
                if (st.cnt == BYTE_ZERO) begin
                    if (!st.scl_oe_n) begin
                        next_st.scl_oe_n = 1'b1;
                        next_st.cnt = SU_CNT;
                    end else begin
                        next_st.sda_oe_n = 1'b1;
                        next_st.state = M_BUF;
                        next_st.cnt = BUF_CNT;
                    end
                end
            end
            M_BUF: begin
                if (st.cnt == BYTE_ZERO) begin
                    next_st.state = M_IDLE;
                    next_st.ready = 1'b1;
                end
            end
            default: begin
                next_st.state = M_IDLE;
            end
        endcase
        if (!nrst) begin
            next_st = '0;
            next_st.state = M_IDLE;
            next_st.phase = P_ADDR_W;
            next_st.scl_oe_n = 1'b1;
            next_st.sda_oe_n = 1'b1;
            next_st.ready = 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        st <= next_st;
    end
    assign bus.scl_oe_n = st.scl_oe_n;
    assign bus.sda_m_oe_n = st.sda_oe_n;
    assign cmd_ready = st.ready;
    assign rd_data = st.rdata;
    assign rd_valid = st.rvalid;
    assign nack_seen = st.nack;
endmodule : dsp_master

// ---- include/dsp_pkg.sv ----
// Package for the I2C control port: slave address, bus timing and bit and byte counter constants.
// Assumes a 20 MHz mclk on both ends and an open-drain bus resolved outside the design.
package dsp_pkg;
    localparam int CLK_HZ = 20000000;
    // Minimum SCL high and low, setup and bus free times; times in ns as printed.
    localparam int T_HIGH_NS = 600;
    localparam int T_LOW_NS = 1300;
    localparam int T_SU_NS = 600;
    localparam int T_BUF_NS = 1300;
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * (CLK_HZ / 1000000) + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc
    // Generated SCL runs slower than the minimum to keep margin over the 400 kHz ceiling.
    localparam int HALF_CYC = ns_to_cyc(T_LOW_NS) + 4;
    localparam int SU_CYC = ns_to_cyc(T_SU_NS);
    localparam int BUF_CYC = ns_to_cyc(T_BUF_NS);
    localparam logic [7:0] HALF_CNT = 8'(HALF_CYC);
    localparam logic [7:0] SU_CNT = 8'(SU_CYC);
    localparam logic [7:0] BUF_CNT = 8'(BUF_CYC);
    localparam logic [3:0] ADDR_FIXED = 4'hd;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] IDX_ONE = 8'h01;
    localparam int NUM_REGS = 256;
endpackage : dsp_pkg

// ---- include/dsp_if.sv ----
// Two-wire link between the master end and the slave end.
// Each end drives an output enable that is low while it pulls the line low; the interface resolves the wire.
interface dsp_if;
    logic scl_oe_n;
    logic sda_m_oe_n;
    logic sda_s_oe_n;
    logic scl;
    logic sda;
    assign scl = scl_oe_n;
    assign sda = sda_m_oe_n & sda_s_oe_n;
    modport master (output scl_oe_n, output sda_m_oe_n, input scl, input sda);
    modport slave (output sda_s_oe_n, input scl, input sda);
endinterface : dsp_if

// ---- src/dsp_sync.sv ----
// Two-flop synchroniser with edge flags taken from the second stage onward.
// Assumes the input is asynchronous to mclk.
module dsp_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Pin and synchronised view
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } dsp_sync_t;
    dsp_sync_t st, next_st;
    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (!nrst) begin
            next_st = '1;
        end
    end
    always_ff @(posedge mclk) begin
        st <= next_st;
    end
    assign level = st.s2;
    assign rise = st.s2 & ~st.s3;
    assign fall = ~st.s2 & st.s3;
endmodule : dsp_sync

// ---- src/dsp_slave.sv ----
// Slave end of the I2C control port with a byte register file and auto-incrementing pointer.
// Assumes SCL and SDA arrive asynchronously and the wire is resolved outside by the interface.
// Functional notes
// - Bytes eight bits, MSB first, one per clock.
// - Receiver acknowledges in the ninth clock.
// - SDA edges while SCL high: start, stop.
// - Data changes only while SCL is low.
// - Acknowledge holds SDA low whole clock.
// - First byte: address plus direction bit.
// - Address is 1101 then three strap pins.
// - Unlimited data bytes per transfer.
// - All registers: single and multi byte.
// - Write: address, index, data, each acknowledged.
// - Index sets start, later bytes increment.
// - Read: write index, repeated start, read.
// - Read returns bytes, pointer advances each.
// - Master acks all but last byte.
module dsp_slave (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Two-wire link
    dsp_if.slave bus,
    // Address straps
    input wire logic slave_id_pin_msb,
    input wire logic slave_id_pin_mid,
    input wire logic slave_id_pin_lsb,
    // Register file view
    output logic [7:0] reg_wr_index,
    output logic [7:0] reg_wr_data,
    output logic reg_wr_strobe,
    output logic busy
);
    import dsp_pkg::*;
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_ADDR = 6'b000010,
        S_INDEX = 6'b000100,
        S_WDATA = 6'b001000,
        S_RDATA = 6'b010000,
        S_IGNORE = 6'b100000
    } dsp_sstate_t;
    typedef struct packed {
        dsp_sstate_t state;
        logic [7:0] shift;
        logic [3:0] bitn;
        logic ack_phase;
        logic rd_nack;
        logic [7:0] ptr;
        logic [2:0] strap;
        logic sda_oe_n;
        logic [7:0] wr_index;
        logic [7:0] wr_data;
        logic wr_strobe;
        logic busy;
    } dsp_slave_t;
    dsp_slave_t st, next_st;
    logic [7:0] regs [NUM_REGS];
    logic scl_lvl, scl_rise, scl_fall, sda_lvl, sda_rise, sda_fall;
    logic start_cond, stop_cond;
    dsp_sync u_scl (.mclk(mclk), .nrst(nrst), .pin(bus.scl), .level(scl_lvl), .rise(scl_rise), .fall(scl_fall));
    dsp_sync u_sda (.mclk(mclk), .nrst(nrst), .pin(bus.sda), .level(sda_lvl), .rise(sda_rise), .fall(sda_fall));
    // Straps are synchronised like any pin before use.
    logic [2:0] strap_s1, strap_s2;
    always_ff @(posedge mclk) begin
        strap_s1 <= {slave_id_pin_msb, slave_id_pin_mid, slave_id_pin_lsb};
        strap_s2 <= strap_s1;
    end
    assign start_cond = scl_lvl & sda_fall;
    assign stop_cond = scl_lvl & sda_rise;
    always_comb begin
        next_st = st;
        next_st.wr_strobe = 1'b0;
        next_st.strap = strap_s2;
        if (start_cond) begin
            // A repeated start keeps the pointer so a read follows the written index.
            next_st.state = S_ADDR;
            next_st.bitn = BIT_ZERO;
            next_st.ack_phase = 1'b0;
            next_st.sda_oe_n = 1'b1;
            next_st.busy = 1'b1;
        end else if (stop_cond) begin
            next_st.state = S_IDLE;
            next_st.sda_oe_n = 1'b1;
            next_st.busy = 1'b0;
        end else if (st.state != S_IDLE && st.state != S_IGNORE) begin
            if (scl_rise && !st.ack_phase) begin
                // While sending, the shift register holds the outgoing byte and must not take in the bus.
                if (st.state != S_RDATA) begin
                    next_st.shift = {st.shift[6:0], sda_lvl};
                end
                next_st.bitn = st.bitn + BIT_ONE;
            end else if (scl_rise && st.ack_phase && st.state == S_RDATA) begin
                next_st.rd_nack = sda_lvl;
            end else if (scl_fall && !st.ack_phase && st.bitn == BIT_ACK) begin
                // Eighth bit done: drive the ninth clock as acknowledge or release.
                next_st.ack_phase = 1'b1;
                next_st.bitn = BIT_ZERO;
                case (st.state)
                    S_ADDR: begin
                        if (st.shift[7:1] == {ADDR_FIXED, st.strap}) begin
                            next_st.sda_oe_n = 1'b0;
                            next_st.state = st.shift[0] ? S_RDATA : S_INDEX;
                        end else begin
                            next_st.state = S_IGNORE;
                            next_st.sda_oe_n = 1'b1;
                        end
                    end
                    S_INDEX: begin
                        next_st.ptr = st.shift;
                        next_st.sda_oe_n = 1'b0;
                        next_st.state = S_WDATA;
                    end
                    S_WDATA: begin
                        next_st.wr_index = st.ptr;
                        next_st.wr_data = st.shift;
                        next_st.wr_strobe = 1'b1;
                        next_st.ptr = st.ptr + IDX_ONE;
                        next_st.sda_oe_n = 1'b0;
                    end
                    S_RDATA: begin
                        next_st.sda_oe_n = 1'b1; // Master answers.
                        next_st.ptr = st.ptr + IDX_ONE;
                    end
                    default: begin
                        next_st.state = S_IGNORE;
                    end
                endcase
            end else if (scl_fall && st.ack_phase) begin
                // End of the ninth clock: the acknowledge low is held to here.
                next_st.ack_phase = 1'b0;
                next_st.sda_oe_n = 1'b1;
                if (st.state == S_RDATA) begin
                    if (st.rd_nack) begin
                        next_st.state = S_IGNORE;
                    end else begin
                        next_st.shift = regs[st.ptr];
                        next_st.sda_oe_n = regs[st.ptr][7];
                        next_st.bitn = BIT_ZERO;
                    end
                end
            end else if (scl_fall && st.state == S_RDATA) begin
                // Bits are counted on rises only, so a fall just moves the next bit to the line.
                next_st.shift = {st.shift[6:0], 1'b0};
                next_st.sda_oe_n = st.shift[6];
            end
            if (st.state == S_RDATA && st.ack_phase && scl_fall && !st.rd_nack && st.bitn == BIT_ZERO) begin
                next_st.state = S_RDATA;
            end
        end
        // Entering a read, the first byte is loaded as the address acknowledge ends.
        if (!start_cond && !stop_cond && st.state == S_RDATA && st.ack_phase && scl_fall && !st.rd_nack) begin
            next_st.rd_nack = 1'b0;
        end
        if (!nrst) begin
            next_st = '0;
            next_st.state = S_IDLE;
            next_st.sda_oe_n = 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        st <= next_st;
        if (st.wr_strobe) begin
            regs[st.wr_index] <= st.wr_data;
        end
    end
    assign bus.sda_s_oe_n = st.sda_oe_n;
    assign reg_wr_index = st.wr_index;
    assign reg_wr_data = st.wr_data;
    assign reg_wr_strobe = st.wr_strobe;
    assign busy = st.busy;
endmodule : dsp_slave

// ---- tb/dsp_chk.sv ----
// Protocol checker for the two-wire link between the master and slave ends.
// Assumes every link signal is registered on mclk, so it is sampled directly.
module dsp_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Link enables and wire levels
    input wire logic scl_oe_n,
    input wire logic sda_m_oe_n,
    input wire logic sda_s_oe_n,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q;
    logic sda_q;
    logic [15:0] bitcnt;
    logic edge_hi;
    // SDA moving while SCL stays high is a start or a stop.
    assign edge_hi = scl && scl_q && (sda != sda_q);
    // Clock rises since the last start or stop; one extra rise precedes each stop or repeated start.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bitcnt <= 16'h0000;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (edge_hi) begin
                bitcnt <= 16'h0000;
            end else if (scl && !scl_q) begin
                bitcnt <= bitcnt + 16'h0001;
            end
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    AST_SCL_HIGH_MIN: assert property ($rose(scl_oe_n) |-> scl [*8])
        else $error("clock high phase too short");
    AST_SCL_LOW_MIN: assert property ($fell(scl) |-> (!scl) [*8])
        else $error("clock low phase too short");
    AST_FRAME_BITS: assert property (edge_hi |-> (bitcnt == 16'h0000) || (bitcnt % 16'h0009 == 16'h0001))
        else $error("start or stop inside a nine clock byte slot");
    AST_START_HOLD: assert property (edge_hi && !sda |-> (!sda_m_oe_n && scl) [*8])
        else $error("start not made or held by the master");
    AST_SLV_CHANGE_LOW: assert property ($changed(sda_s_oe_n) |-> !scl)
        else $error("slave moved data while clock high");
    AST_ACK_WHOLE: assert property ($rose(scl) && !sda_s_oe_n |-> !sda_s_oe_n throughout (##[1:200] $fell(scl)))
        else $error("slave let go of a low bit before clock fell");
    AST_ADDR_NO_DRIVE: assert property (bitcnt < 16'h0008 |-> sda_s_oe_n)
        else $error("slave drove data during the address byte");
    AST_STOP_RELEASED: assert property (edge_hi && sda |-> (sda_s_oe_n && sda) [*8])
        else $error("data line not released after stop");
endmodule : dsp_chk

// ---- tb/dsp_tb_top.sv ----
// Testbench joining the master and slave ends through the link interface.
// Assumes the master makes the link clock and one command runs at a time.
module dsp_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dsp_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] id_pins = 3'h0;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [7:0] cmd_index = 8'h00;
    logic [7:0] cmd_data = 8'h00;
    logic [7:0] cmd_count = 8'h01;
    logic cmd_ready, rd_valid, nack_seen, reg_wr_strobe, busy;
    logic [7:0] rd_data, reg_wr_index, reg_wr_data;
    logic [7:0] rq[$];
    logic [15:0] wq[$];
    int sdrv;
    int err_count = 0;
    int n_tests = 0;
    dsp_if link();
    dsp_master dsp_master_i(.mclk(mclk), .nrst(nrst), .bus(link.master), .cmd_valid(cmd_valid),
        .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_index(cmd_index), .cmd_data(cmd_data),
        .cmd_count(cmd_count), .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .nack_seen(nack_seen));
    dsp_slave dsp_slave_i(.mclk(mclk), .nrst(nrst), .bus(link.slave), .slave_id_pin_msb(id_pins[2]),
        .slave_id_pin_mid(id_pins[1]), .slave_id_pin_lsb(id_pins[0]), .reg_wr_index(reg_wr_index),
        .reg_wr_data(reg_wr_data), .reg_wr_strobe(reg_wr_strobe), .busy(busy));
    dsp_chk dsp_chk_i(.mclk(mclk), .nrst(nrst), .scl_oe_n(link.scl_oe_n), .sda_m_oe_n(link.sda_m_oe_n),
        .sda_s_oe_n(link.sda_s_oe_n), .scl(link.scl), .sda(link.sda));
    always #25 mclk = ~mclk;
    // Pulses are registered, so each edge sees the value launched by the edge before.
    always @(posedge mclk) begin
        if (rd_valid === 1'b1) rq.push_back(rd_data);
        if (reg_wr_strobe === 1'b1) wq.push_back({reg_wr_index, reg_wr_data});
        if (link.sda_s_oe_n === 1'b0) sdrv++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One command from request to the master being idle again.
    task automatic run_cmd(input logic rd, input logic [6:0] addr, input logic [7:0] idx,
        input logic [7:0] dat, input logic [7:0] cnt);
        int i;
        rq.delete();
        wq.delete();
        sdrv = 0;
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_addr = addr;
        cmd_index = idx;
        cmd_data = dat;
        cmd_count = cnt;
        @(negedge mclk);
        cmd_valid = 1'b0;
        for (i = 0; i < 20000 && cmd_ready !== 1'b1; i++) @(negedge mclk);
        if (i == 20000) begin
            err_count++;
            $display("mismatch at %0t: transfer never finished", $time);
            report_and_stop();
        end
    endtask : run_cmd
    task automatic set_pins(input logic [2:0] v);
        @(negedge mclk);
        id_pins = v;
        repeat (4) @(negedge mclk);
    endtask : set_pins
    ////////////////////////////////////////////////////////////////////////////
    task automatic sc_straps();
        for (int k = 0; k < 8; k++) begin
            set_pins(k[2:0]);
            run_cmd(1'b0, {ADDR_FIXED, k[2:0]}, 8'h20 + 8'(k), 8'hA0 + 8'(k), 8'h01);
            check({15'h0000, nack_seen}, 16'h0000);
            check(16'(wq.size()), 16'h0001);
            check(wq.size() > 0 ? wq[0] : 16'hxxxx, {8'h20 + 8'(k), 8'hA0 + 8'(k)});
        end
    endtask : sc_straps
    task automatic sc_multi_write();
        set_pins(3'h5);
        run_cmd(1'b0, {ADDR_FIXED, 3'h5}, 8'hFE, 8'h5A, 8'h03);
        check(16'(wq.size()), 16'h0003);
        for (int j = 0; j < 3; j++) begin
            check(wq.size() > j ? wq[j] : 16'hxxxx, {8'hFE + 8'(j), 8'h5A});
        end
    endtask : sc_multi_write
    task automatic sc_read();
        run_cmd(1'b1, {ADDR_FIXED, 3'h5}, 8'h20, 8'h00, 8'h08);
        check(16'(rq.size()), 16'h0008);
        check({15'h0000, nack_seen}, 16'h0000);
        check(16'(wq.size()), 16'h0000);
        for (int j = 0; j < 8; j++) begin
            check(rq.size() > j ? {8'h00, rq[j]} : 16'hxxxx, {8'h00, 8'hA0 + 8'(j)});
        end
        run_cmd(1'b1, {ADDR_FIXED, 3'h5}, 8'hFF, 8'h00, 8'h02);
        check(16'(rq.size()), 16'h0002);
        check(rq.size() > 1 ? {rq[0], rq[1]} : 16'hxxxx, 16'h5A5A);
    endtask : sc_read
    task automatic sc_mismatch();
        for (int j = 0; j < 2; j++) begin
            run_cmd(1'b0, (j == 0) ? {ADDR_FIXED, 3'h2} : 7'h4D, 8'h40, 8'h3C, 8'h01);
            check({15'h0000, nack_seen}, 16'h0001);
            check(16'(wq.size() + sdrv), 16'h0000);
            check({15'h0000, busy}, 16'h0000);
        end
        run_cmd(1'b0, {ADDR_FIXED, 3'h5}, 8'h40, 8'h3C, 8'h01);
        check(wq.size() > 0 ? wq[0] : 16'hxxxx, 16'h403C);
        run_cmd(1'b1, {ADDR_FIXED, 3'h5}, 8'h40, 8'h00, 8'h01);
        check(rq.size() > 0 ? {8'h00, rq[0]} : 16'hxxxx, 16'h003C);
    endtask : sc_mismatch
    initial begin
        repeat (8) @(negedge mclk);
        nrst = 1'b1;
        sc_straps();
        sc_multi_write();
        sc_read();
        sc_mismatch();
        report_and_stop();
    end
endmodule : dsp_tb_top
